// File: dtm_pkg.sv
// constants, register map and carrier types of the dual timer block
// assumes one 100 MHz clock that also stands for the oscillator
`default_nettype none

package dtm_pkg;

    // byte addresses on the register bus
    localparam logic [11:0] ADR_TIMER_CONTROL = 12'h410;
    localparam logic [11:0] ADR_TOGGLE_STATUS = 12'h420;
    localparam logic [11:0] ADR_RELOAD0       = 12'h424;
    localparam logic [11:0] ADR_RELOAD1       = 12'h428;
    localparam logic [11:0] ADR_COUNT0        = 12'h430;
    localparam logic [11:0] ADR_COUNT1        = 12'h434;
    localparam logic [11:0] ADR_PRESCALE      = 12'h440;
    localparam logic [11:0] ADR_TIMER_MODE    = 12'h45c;

    // timer_control bit positions
    localparam int TC_TF1 = 7;
    localparam int TC_TR1 = 6;
    localparam int TC_TF0 = 5;
    localparam int TC_TR0 = 4;
    localparam int TC_IE1 = 3;
    localparam int TC_IT1 = 2;
    localparam int TC_IE0 = 1;
    localparam int TC_IT0 = 0;

    // timer_mode_register: timer 0 in [3:0], timer 1 in [7:4]
    localparam int TM_T0_MODE = 0;
    localparam int TM_T0_CT   = 2;
    localparam int TM_T0_GATE = 3;
    localparam int TM_T1_MODE = 4;
    localparam int TM_T1_CT   = 6;
    localparam int TM_T1_GATE = 7;

    // toggle_status_register enables
    localparam int TS_T0_TOGGLE = 0;
    localparam int TS_T1_TOGGLE = 2;

    // prescale select sits in bits [3:2] of the prescale register
    localparam int PS_SEL = 2;

    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // prescaler terminal counts for divide by 4, 16 and 64
    localparam logic [5:0] PRESC_MAX4  = 6'h03;
    localparam logic [5:0] PRESC_MAX16 = 6'h0f;
    localparam logic [5:0] PRESC_MAX64 = 6'h3f;

    // pins are looked at once per this many oscillator cycles
    localparam int SAMPLE_PERIOD = 2;

    typedef enum logic [1:0] {
        MODE_RELOAD16 = 2'h0,
        MODE_COUNT16  = 2'h1,
        MODE_RELOAD8  = 2'h2,
        MODE_SPLIT8   = 2'h3
    } dtm_mode_type;

    typedef enum logic [1:0] {
        PRESC_DIV4  = 2'h0,
        PRESC_DIV16 = 2'h1,
        PRESC_DIV64 = 2'h2,
        PRESC_RSVD  = 2'h3
    } dtm_presc_type;

    // four pins, also the bit order inside the sampler
    typedef struct packed {
        logic t1_count;
        logic t0_count;
        logic ext_irq1;
        logic ext_irq0;
    } dtm_pins_type;

    // interrupt-facing flags and their service acknowledges
    typedef struct packed {
        logic t1_ovf;
        logic t0_ovf;
        logic ext1;
        logic ext0;
    } dtm_irq_type;

    typedef struct packed {
        logic [7:0]  timer_control;
        logic [7:0]  timer_mode_register;
        logic [1:0]  presc;
        logic [7:0]  toggle_status_register;
        logic [7:0]  rl0;
        logic [7:0]  rl1;
        logic [15:0] cnt0;
        logic [15:0] cnt1;
        logic [5:0]  pcnt;
        logic        ack;
        logic [31:0] rdat;
    } dtm_state_type;

endpackage

`default_nettype wire

// File: dtm_pin_sampler.sv
// samples four pins every second cycle, gives levels and falling edges
// assumes pins already synchronous to clk_i
`default_nettype none

module dtm_pin_sampler (
    input  wire logic       clk_i,   // system clock
    input  wire logic       rst_i,   // sync reset, high
    input  wire logic [3:0] pin_i,   // raw pin levels
    output logic      [3:0] level_o, // last sampled level
    output logic      [3:0] fall_o   // one-cycle falling edge pulse
);

    typedef struct packed {
        logic       phase;
        logic [3:0] cur;
        logic [3:0] fall;
    } dtm_smp_type;

    dtm_smp_type s_q;
    dtm_smp_type s_d;

    always_comb
    begin
        s_d       = s_q;
        s_d.phase = ~s_q.phase;
        s_d.fall  = 4'h0;
        // a level shorter than two cycles may be missed entirely
        if (s_q.phase)
        begin
            s_d.cur  = pin_i;
            s_d.fall = s_q.cur & ~pin_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q.phase <= 1'b0;
            s_q.cur   <= 4'hf;
            s_q.fall  <= 4'h0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.cur;
    assign fall_o  = s_q.fall;

endmodule

`default_nettype wire

// File: dtm_timers.sv
// timers 0 and 1 with the shared control register, Wishbone slave
// assumes a classic Wishbone master and pins synchronous to clk_i
//
// The Wishbone register port was left to the implementer.
`default_nettype none

module dtm_timers (
    input  wire logic                 clk_i,     // system clock
    input  wire logic                 rst_i,     // sync reset, high
    input  wire logic                 wb_cyc_i,  // bus cycle
    input  wire logic                 wb_stb_i,  // bus strobe
    input  wire logic                 wb_we_i,   // write enable
    input  wire logic [11:0]          wb_adr_i,  // byte address
    input  wire logic [3:0]           wb_sel_i,  // byte lanes
    input  wire logic [31:0]          wb_dat_i,  // write data
    output logic      [31:0]          wb_dat_o,  // read data
    output logic                      wb_ack_o,  // bus acknowledge
    input  wire dtm_pkg::dtm_pins_type pins_i,   // count and ext pins
    input  wire dtm_pkg::dtm_irq_type  svc_i,    // vector pulses
    output dtm_pkg::dtm_irq_type       irq_o     // pending flags
);

    dtm_pkg::dtm_state_type s_q;
    dtm_pkg::dtm_state_type s_d;

    logic [3:0]            lvl;
    logic [3:0]            fall;
    logic                  req;
    logic                  wr;
    logic                  tick;
    logic [5:0]            pmax;
    logic                  en0;
    logic                  en1;
    logic                  inc0;
    logic                  inc1;
    logic                  set_tf0;
    logic                  set_tf1;
    logic                  t1_ovf;
    logic                  set_ie0;
    logic                  set_ie1;
    dtm_pkg::dtm_mode_type mode0;
    dtm_pkg::dtm_mode_type mode1;
    dtm_pkg::dtm_pins_type pins;

    assign pins = pins_i;

    dtm_pin_sampler u_sampler (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pins),
        .level_o (lvl),
        .fall_o  (fall)
    );

    always_comb
    begin
        s_d     = s_q;
        req     = wb_cyc_i & wb_stb_i & ~s_q.ack;
        wr      = req & wb_we_i;
        set_tf0 = 1'b0;
        set_tf1 = 1'b0;
        t1_ovf  = 1'b0;
        mode0   = dtm_pkg::dtm_mode_type'(s_q.timer_mode_register[dtm_pkg::TM_T0_MODE +: 2]);
        mode1   = dtm_pkg::dtm_mode_type'(s_q.timer_mode_register[dtm_pkg::TM_T1_MODE +: 2]);

        // one shared prescaler for both timers
        unique case (dtm_pkg::dtm_presc_type'(s_q.presc))
            dtm_pkg::PRESC_DIV16: pmax = dtm_pkg::PRESC_MAX16;
            dtm_pkg::PRESC_DIV64: pmax = dtm_pkg::PRESC_MAX64;
            default:              pmax = dtm_pkg::PRESC_MAX4;
        endcase
        tick = (s_q.pcnt >= pmax);
        if (tick)
        begin
            s_d.pcnt = 6'h00;
        end
        else
        begin
            s_d.pcnt = s_q.pcnt + 6'h01;
        end

        // gating and source selection
        en0  = s_q.timer_control[dtm_pkg::TC_TR0]
             & (~s_q.timer_mode_register[dtm_pkg::TM_T0_GATE] | lvl[0]);
        en1  = s_q.timer_control[dtm_pkg::TC_TR1]
             & (~s_q.timer_mode_register[dtm_pkg::TM_T1_GATE] | lvl[1]);
        inc0 = en0 & (s_q.timer_mode_register[dtm_pkg::TM_T0_CT] ? fall[2] : tick);
        inc1 = en1 & (s_q.timer_mode_register[dtm_pkg::TM_T1_CT] ? fall[3] : tick);

        // timer 0
        unique case (mode0)
            dtm_pkg::MODE_SPLIT8:
            begin
                if (inc0)
                begin
                    s_d.cnt0[7:0] = s_q.cnt0[7:0] + 8'h01;
                    set_tf0       = (s_q.cnt0[7:0] == 8'hff);
                end
                // high byte: internal tick, timer 1 run bit
                if (s_q.timer_control[dtm_pkg::TC_TR1] & tick)
                begin
                    s_d.cnt0[15:8] = s_q.cnt0[15:8] + 8'h01;
                    set_tf1        = (s_q.cnt0[15:8] == 8'hff);
                end
            end
            dtm_pkg::MODE_RELOAD8:
            begin
                if (inc0)
                begin
                    if (s_q.cnt0[7:0] == 8'hff)
                    begin
                        s_d.cnt0[7:0] = s_q.rl0;
                        set_tf0       = 1'b1;
                    end
                    else
                    begin
                        s_d.cnt0[7:0] = s_q.cnt0[7:0] + 8'h01;
                    end
                end
            end
            default:
            begin
                // reload16 is not built here and runs like count16
                if (inc0)
                begin
                    s_d.cnt0 = s_q.cnt0 + 16'h0001;
                    set_tf0  = (s_q.cnt0 == 16'hffff);
                end
            end
        endcase

        // timer 1
        unique case (mode1)
            dtm_pkg::MODE_SPLIT8:
            begin
                // hold, same as run bit clear
                s_d.cnt1 = s_q.cnt1;
            end
            dtm_pkg::MODE_RELOAD8:
            begin
                if (inc1)
                begin
                    if (s_q.cnt1[7:0] == 8'hff)
                    begin
                        s_d.cnt1[7:0] = s_q.rl1;
                        t1_ovf        = 1'b1;
                    end
                    else
                    begin
                        s_d.cnt1[7:0] = s_q.cnt1[7:0] + 8'h01;
                    end
                end
            end
            default:
            begin
                if (inc1)
                begin
                    s_d.cnt1 = s_q.cnt1 + 16'h0001;
                    t1_ovf   = (s_q.cnt1 == 16'hffff);
                end
            end
        endcase

        // timer 0 split owns the timer 1 flag
        if (mode0 != dtm_pkg::MODE_SPLIT8)
        begin
            set_tf1 = t1_ovf;
        end

        // toggle output enables suppress the flags
        set_tf0 = set_tf0 & ~s_q.toggle_status_register[dtm_pkg::TS_T0_TOGGLE];
        set_tf1 = set_tf1 & ~s_q.toggle_status_register[dtm_pkg::TS_T1_TOGGLE];

        // external trigger: falling edge or low level
        set_ie0 = s_q.timer_control[dtm_pkg::TC_IT0] ? fall[0] : ~lvl[0];
        set_ie1 = s_q.timer_control[dtm_pkg::TC_IT1] ? fall[1] : ~lvl[1];

        // register writes; a software write beats a count this cycle
        if (wr & wb_sel_i[0])
        begin
            unique case (wb_adr_i)
                dtm_pkg::ADR_TIMER_CONTROL: s_d.timer_control = wb_dat_i[7:0];
                dtm_pkg::ADR_TIMER_MODE:    s_d.timer_mode_register = wb_dat_i[7:0];
                dtm_pkg::ADR_TOGGLE_STATUS: s_d.toggle_status_register = wb_dat_i[7:0];
                dtm_pkg::ADR_RELOAD0:       s_d.rl0 = wb_dat_i[7:0];
                dtm_pkg::ADR_RELOAD1:       s_d.rl1 = wb_dat_i[7:0];
                dtm_pkg::ADR_PRESCALE:      s_d.presc = wb_dat_i[dtm_pkg::PS_SEL +: 2];
                dtm_pkg::ADR_COUNT0:        s_d.cnt0[7:0] = wb_dat_i[7:0];
                dtm_pkg::ADR_COUNT1:        s_d.cnt1[7:0] = wb_dat_i[7:0];
                default:                    s_d.rl0 = s_d.rl0;
            endcase
        end
        if (wr & wb_sel_i[1])
        begin
            if (wb_adr_i == dtm_pkg::ADR_COUNT0)
            begin
                s_d.cnt0[15:8] = wb_dat_i[15:8];
            end
            if (wb_adr_i == dtm_pkg::ADR_COUNT1)
            begin
                s_d.cnt1[15:8] = wb_dat_i[15:8];
            end
        end

        // service clears the flag; a set in the same cycle wins
        if (svc_i.t0_ovf)
        begin
            s_d.timer_control[dtm_pkg::TC_TF0] = 1'b0;
        end
        if (svc_i.t1_ovf)
        begin
            s_d.timer_control[dtm_pkg::TC_TF1] = 1'b0;
        end
        if (svc_i.ext0)
        begin
            s_d.timer_control[dtm_pkg::TC_IE0] = 1'b0;
        end
        if (svc_i.ext1)
        begin
            s_d.timer_control[dtm_pkg::TC_IE1] = 1'b0;
        end
        s_d.timer_control[dtm_pkg::TC_TF0] = s_d.timer_control[dtm_pkg::TC_TF0] | set_tf0;
        s_d.timer_control[dtm_pkg::TC_TF1] = s_d.timer_control[dtm_pkg::TC_TF1] | set_tf1;
        s_d.timer_control[dtm_pkg::TC_IE0] = s_d.timer_control[dtm_pkg::TC_IE0] | set_ie0;
        s_d.timer_control[dtm_pkg::TC_IE1] = s_d.timer_control[dtm_pkg::TC_IE1] | set_ie1;

        // one wait state: ack and data in the cycle after the request
        s_d.ack  = req;
        s_d.rdat = 32'h0000_0000;
        if (req & ~wb_we_i)
        begin
            unique case (wb_adr_i)
                dtm_pkg::ADR_TIMER_CONTROL: s_d.rdat[7:0] = s_q.timer_control;
                dtm_pkg::ADR_TIMER_MODE:    s_d.rdat[7:0] = s_q.timer_mode_register;
                dtm_pkg::ADR_TOGGLE_STATUS: s_d.rdat[7:0] = s_q.toggle_status_register;
                dtm_pkg::ADR_RELOAD0:       s_d.rdat[7:0] = s_q.rl0;
                dtm_pkg::ADR_RELOAD1:       s_d.rdat[7:0] = s_q.rl1;
                dtm_pkg::ADR_PRESCALE:      s_d.rdat[dtm_pkg::PS_SEL +: 2] = s_q.presc;
                dtm_pkg::ADR_COUNT0:        s_d.rdat[15:0] = s_q.cnt0;
                dtm_pkg::ADR_COUNT1:        s_d.rdat[15:0] = s_q.cnt1;
                default:                    s_d.rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q.timer_control  <= dtm_pkg::RST_BYTE;
            s_q.timer_mode_register  <= dtm_pkg::RST_BYTE;
            s_q.presc <= 2'h0;
            s_q.toggle_status_register <= dtm_pkg::RST_BYTE;
            s_q.rl0   <= dtm_pkg::RST_BYTE;
            s_q.rl1   <= dtm_pkg::RST_BYTE;
            s_q.cnt0  <= dtm_pkg::RST_WORD;
            s_q.cnt1  <= dtm_pkg::RST_WORD;
            s_q.pcnt  <= 6'h00;
            s_q.ack   <= 1'b0;
            s_q.rdat  <= 32'h0000_0000;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o      = s_q.ack;
    assign wb_dat_o      = s_q.rdat;
    assign irq_o.t1_ovf  = s_q.timer_control[dtm_pkg::TC_TF1];
    assign irq_o.t0_ovf  = s_q.timer_control[dtm_pkg::TC_TF0];
    assign irq_o.ext1    = s_q.timer_control[dtm_pkg::TC_IE1];
    assign irq_o.ext0    = s_q.timer_control[dtm_pkg::TC_IE0];

endmodule

`default_nettype wire

// File: dtm_timers_chk.sv
// concurrent checks on bus timing and external flags of the dual timer block
// assumes it is bound to dtm_timers and sees only its ports
`default_nettype none

module dtm_timers_chk (
    input wire logic                  clk_i,    // system clock
    input wire logic                  rst_i,    // sync reset, high
    input wire logic                  wb_cyc_i, // bus cycle
    input wire logic                  wb_stb_i, // bus strobe
    input wire logic                  wb_we_i,  // write enable
    input wire logic [11:0]           wb_adr_i, // byte address
    input wire logic [31:0]           wb_dat_o, // read data
    input wire logic                  wb_ack_o, // acknowledge
    input wire dtm_pkg::dtm_pins_type pins_i,   // pins
    input wire dtm_pkg::dtm_irq_type  svc_i,    // service pulses
    input wire dtm_pkg::dtm_irq_type  irq_o     // pending flags
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // cycles the ext 1 pin has been high; 8 means no edge or low level can be in flight
    logic [3:0] hi1_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !pins_i.ext_irq1)
            hi1_q <= 4'h0;
        else if (hi1_q != 4'h8)
            hi1_q <= hi1_q + 4'h1;
    end

    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence answer_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_answer_a: assert property (req_s |=> answer_s)
        else $error("bus request not answered by one ack pulse");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    unmapped_read_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h000) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    reset_clear_a: assert property ($fell(rst_i) |-> irq_o == 4'h0 && !wb_ack_o)
        else $error("flags or ack not cleared by reset");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ext_clear_a: assert property (svc_i.ext1 && hi1_q == 4'h8 && !(wb_cyc_i && wb_we_i) |=> !irq_o.ext1)
        else $error("ext 1 flag not cleared by service");
    ext_cause_a: assert property ($rose(irq_o.ext1) |-> hi1_q != 4'h8 || $past(wb_cyc_i && wb_we_i))
        else $error("ext 1 flag set with pin idle high");
endmodule

bind dtm_timers dtm_timers_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins_i),
    .svc_i(svc_i), .irq_o(irq_o));

`default_nettype wire

// File: dtm_timers_tb.sv
// self-checking bench of the dual timer block
// assumes dtm_pkg, dtm_timers and its checker compiled first
`default_nettype none

module dtm_timers_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic                  cyc = 1'b0;
    logic                  stb = 1'b0;
    logic                  we = 1'b0;
    logic [11:0]           adr = 12'h000;
    logic [3:0]            sel = 4'h0;
    logic [31:0]           wdat = 32'h0;
    logic [31:0]           rdat;
    logic                  ack;
    logic [31:0]           r;
    dtm_pkg::dtm_pins_type pins = 4'hf;
    dtm_pkg::dtm_irq_type  svc = 4'h0;
    dtm_pkg::dtm_irq_type  irq;
    int                    miscompares = 0;
    int                    num_checks = 0;

    always #5 clk_i = ~clk_i;

    dtm_timers DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pins_i(pins), .svc_i(svc), .irq_o(irq));

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // values read right after an edge are those the design held at that edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'h3;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        chk(ack, 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (irq[b] !== 1'b1 && n < 3000);
    endtask

    // cycles from one overflow flag rise to the next, service pulse in between
    task automatic period(input int b, input int p);
        int n;
        wait_flag(b);
        svc <= dtm_pkg::dtm_irq_type'(4'h1 << b);
        @(posedge clk_i);
        svc <= 4'h0;
        n = 1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (irq[b] !== 1'b1 && n < 3000);
        chk(n, p);
    endtask

    task automatic pulse(input int k);
        repeat (k)
        begin
            pins.t0_count <= 1'b0;
            repeat (4) @(posedge clk_i);
            pins.t0_count <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
    endtask

    task automatic t_reset;
        bus(1'b0, dtm_pkg::ADR_TIMER_CONTROL, 32'h0);
        chk(r, 32'h0);
        chk(irq, 4'h0);
        bus(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h55);
        bus(1'b0, dtm_pkg::ADR_TIMER_CONTROL, 32'h0);
        chk(r, 32'h55);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h0);
    endtask

    task automatic t_mode1;
        bus(1'b1, dtm_pkg::ADR_TIMER_MODE, 32'h01);
        bus(1'b1, dtm_pkg::ADR_COUNT0, 32'hfffe);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h10);
        wait_flag(2);
        chk(irq[2], 1'b1);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h0);
        chk(irq[2], 1'b0);
        bus(1'b0, dtm_pkg::ADR_COUNT0, 32'h0);
        chk(r[15:0], 16'h0000);
    endtask

    task automatic t_mode2(input int t, input int s);
        bus(1'b1, dtm_pkg::ADR_PRESCALE, s << 2);
        bus(1'b1, dtm_pkg::ADR_TIMER_MODE, t ? 32'h20 : 32'h02);
        bus(1'b1, t ? dtm_pkg::ADR_RELOAD1 : dtm_pkg::ADR_RELOAD0, 32'hf0);
        bus(1'b1, t ? dtm_pkg::ADR_COUNT1 : dtm_pkg::ADR_COUNT0, 32'h12f0);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, t ? 32'h40 : 32'h10);
        period(t ? 3 : 2, (4 << (2 * s)) * 16);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h0);
        bus(1'b0, t ? dtm_pkg::ADR_COUNT1 : dtm_pkg::ADR_COUNT0, 32'h0);
        chk(r[15:8], 8'h12);
    endtask

    task automatic t_toggle;
        bus(1'b1, dtm_pkg::ADR_TOGGLE_STATUS, 32'h01);
        bus(1'b1, dtm_pkg::ADR_TIMER_MODE, 32'h02);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h10);
        repeat (300) @(posedge clk_i);
        chk(irq[2], 1'b0);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h0);
        bus(1'b1, dtm_pkg::ADR_TOGGLE_STATUS, 32'h0);
    endtask

    // timer 0 split with counter select set, timer 1 parked in mode 3
    task automatic t_split;
        bus(1'b1, dtm_pkg::ADR_TIMER_MODE, 32'h37);
        bus(1'b1, dtm_pkg::ADR_COUNT0, 32'h00a5);
        bus(1'b1, dtm_pkg::ADR_COUNT1, 32'h0040);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h40);
        period(3, 1024);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h0);
        bus(1'b0, dtm_pkg::ADR_COUNT0, 32'h0);
        chk(r[7:0], 8'ha5);
        bus(1'b0, dtm_pkg::ADR_COUNT1, 32'h0);
        chk(r[15:0], 16'h0040);
    endtask

    task automatic t_counter;
        bus(1'b1, dtm_pkg::ADR_TIMER_MODE, 32'h05);
        bus(1'b1, dtm_pkg::ADR_COUNT0, 32'h0);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h10);
        pulse(5);
        bus(1'b0, dtm_pkg::ADR_COUNT0, 32'h0);
        chk(r[15:0], 16'h0005);
        bus(1'b1, dtm_pkg::ADR_TIMER_MODE, 32'h0d);
        pins.ext_irq0 <= 1'b0;
        repeat (4) @(posedge clk_i);
        pulse(3);
        bus(1'b0, dtm_pkg::ADR_COUNT0, 32'h0);
        chk(r[15:0], 16'h0005);
        chk(irq[0], 1'b1);
        pins.ext_irq0 <= 1'b1;
        repeat (8) @(posedge clk_i);
        pulse(2);
        bus(1'b0, dtm_pkg::ADR_COUNT0, 32'h0);
        chk(r[15:0], 16'h0007);
        svc <= 4'h1;
        @(posedge clk_i);
        svc <= 4'h0;
        repeat (2) @(posedge clk_i);
        chk(irq[0], 1'b0);
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h0);
    endtask

    task automatic t_edge;
        bus(1'b1, dtm_pkg::ADR_TIMER_CONTROL, 32'h04);
        pins.ext_irq1 <= 1'b0;
        repeat (4) @(posedge clk_i);
        pins.ext_irq1 <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(irq[1], 1'b1);
        svc <= 4'h2;
        @(posedge clk_i);
        svc <= 4'h0;
        repeat (2) @(posedge clk_i);
        chk(irq[1], 1'b0);
    endtask

    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mode1();
        for (int s = 0; s < 3; s++)
            t_mode2(0, s);
        t_mode2(1, 0);
        t_toggle();
        t_split();
        t_counter();
        t_edge();
        final_report();
    end

    // whole run is near 5500 cycles
    initial
    begin
        repeat (50000) @(posedge clk_i);
        miscompares++;
        final_report();
    end
endmodule

`default_nettype wire
